/* nv_options_store.sv */
`timescale 1ns/1ps
module nv_options_store
(
    // Clock and control
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Stored cell contents and software write
    input  wire logic [7:0] nv_image,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    // Mirrored value and commit pulse to the cells
    output logic      [7:0] options_o,
    output logic            commit_o
);

    logic [7:0] opt_ff;     // Mirror of the cells
    logic       commit_ff;  // Ask the cells to store opt_ff

    assign options_o = opt_ff;
    assign commit_o  = commit_ff;

    // Reset rereads the cells, so their two live bits come back as they were; the others read zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            opt_ff    <= nv_image & regmap_pkg::OPTIONS_LIVE_BITS;
            commit_ff <= 1'b0;
        end
        else if (ce)
        begin
            commit_ff <= wr;
            if (wr)
            begin
                opt_ff <= wdata & regmap_pkg::OPTIONS_LIVE_BITS;
            end
        end
    end

endmodule : nv_options_store

/* peripheral_register_map_reset.sv */
`timescale 1ns/1ps
module peripheral_register_map_reset
#(
    parameter int ADDR_W = 12  // Byte address width of the bus
)
(
    // Clock, reset and clock enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Reset cause and straps
    input  wire logic              power_on,
    input  wire logic              watchdog_mask_option,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Peripheral update of status bits
    input  wire logic              hw_wr,
    input  wire logic [4:0]        hw_index,
    input  wire logic [7:0]        hw_data,
    // Register image for the peripherals
    output logic [31:0][7:0]       regs_o,
    output logic                   watchdog_enable_bit,
    output logic                   power_on_seen,
    // Nonvolatile options
    input  wire logic [7:0]        nv_image,
    output logic      [7:0]        persistent_options,
    output logic                   security_bit,
    output logic                   nv_commit
);

    // Decoded access shared with the bus port
    reg_access_if acc ();

    // Byte bank for the low registers
    logic [7:0] bank_ff [regmap_pkg::BANK_DEPTH];
    // Power-on flag kept apart from the bank
    logic       power_on_ff;
    // Watchdog enable kept apart from the bank
    logic       watchdog_ff;
    // Options value from the nonvolatile mirror
    logic [7:0] options_val;
    // Write that lands in the low bank
    logic       bank_wr;
    // Write that lands on the options register
    logic       opt_wr;
    // Miscellaneous register value as read
    logic [7:0] misc_val;

    // Bits that exist in a register; others are fixed zero
    function automatic logic [7:0] live_bits(input regmap_pkg::reg_index_t idx);
        logic [7:0] m;
        m = regmap_pkg::ALL_BITS;
        case (idx)
            regmap_pkg::IDX_NV_CLOCK_CONTROL:
                m = regmap_pkg::NV_CLOCK_LIVE_BITS;
            regmap_pkg::IDX_CONVERTER_STATUS:
                m = regmap_pkg::CONV_STATUS_LIVE;
            default:
                m = regmap_pkg::ALL_BITS;
        endcase
        return m;
    endfunction : live_bits

    // Bits that software may write; the rest belong to the peripherals
    function automatic logic [7:0] sw_bits(input regmap_pkg::reg_index_t idx);
        logic [7:0] m;
        m = regmap_pkg::NO_BITS;
        case (idx)
            // Port data, directions and control registers
            regmap_pkg::IDX_PORT_A_VALUE,
            regmap_pkg::IDX_PORT_B_VALUE,
            regmap_pkg::IDX_PORT_C_VALUE,
            regmap_pkg::IDX_PORT_A_DIRECTION,
            regmap_pkg::IDX_PORT_B_DIRECTION,
            regmap_pkg::IDX_PORT_C_DIRECTION,
            regmap_pkg::IDX_PULSE_LENGTH_A,
            regmap_pkg::IDX_PULSE_LENGTH_B,
            regmap_pkg::IDX_SERIAL_RATE,
            regmap_pkg::IDX_SERIAL_CONTROL_ONE,
            regmap_pkg::IDX_SERIAL_CONTROL_TWO,
            regmap_pkg::IDX_SERIAL_BUFFER,
            regmap_pkg::IDX_TIMER_CONTROL,
            regmap_pkg::IDX_COMPARE1_HIGH,
            regmap_pkg::IDX_COMPARE1_LOW,
            regmap_pkg::IDX_COMPARE2_HIGH,
            regmap_pkg::IDX_COMPARE2_LOW:
                m = regmap_pkg::ALL_BITS;
            // Control bits below the fixed zeros
            regmap_pkg::IDX_NV_CLOCK_CONTROL:
                m = regmap_pkg::NV_CLOCK_LIVE_BITS;
            // Conversion-complete flag is the converter's own
            regmap_pkg::IDX_CONVERTER_STATUS:
                m = regmap_pkg::CONV_STATUS_SW_BITS;
            // Flags, results, captures and counters are read only
            default:
                m = regmap_pkg::NO_BITS;
        endcase
        return m;
    endfunction : sw_bits

    // Value a bank register takes on any reset
    function automatic logic [7:0] reset_value(input regmap_pkg::reg_index_t idx);
        logic [7:0] v;
        v = regmap_pkg::RST_ZERO;
        case (idx)
            regmap_pkg::IDX_FREE_COUNTER_HIGH,
            regmap_pkg::IDX_ALT_COUNTER_HIGH:
                v = regmap_pkg::RST_COUNTER_HIGH;
            regmap_pkg::IDX_FREE_COUNTER_LOW,
            regmap_pkg::IDX_ALT_COUNTER_LOW:
                v = regmap_pkg::RST_COUNTER_LOW;
            regmap_pkg::IDX_SERIAL_FLAGS:
                v = regmap_pkg::RST_SERIAL_FLAGS;
            regmap_pkg::IDX_MISC_CONTROL:
                v = regmap_pkg::RST_MISC_BASE;
            // Directions, pulse lengths, serial control two and the
            // undefined registers all start at zero
            default:
                v = regmap_pkg::RST_ZERO;
        endcase
        return v;
    endfunction : reset_value

    // Bus port: handshake and decode
    wb_classic_port #(
        .ADDR_W   (ADDR_W)
    ) u_port (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .acc      (acc.bus)
    );

    // Writes split between the bank and the options register
    assign bank_wr = acc.wr_stb & (acc.index < regmap_pkg::reg_index_t'(regmap_pkg::BANK_DEPTH));
    assign opt_wr  = acc.wr_stb & (acc.index == regmap_pkg::IDX_PERSISTENT_OPTIONS);

    // Options register lives in nonvolatile cells outside this block
    nv_options_store u_options (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .nv_image  (nv_image),
        .wr        (opt_wr),
        .wdata     (acc.wdata),
        .options_o (options_val),
        .commit_o  (nv_commit)
    );

    // Bank update: peripheral bits first, software bits on top.
    // Each side owns disjoint bits, so one never masks the other.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < regmap_pkg::BANK_DEPTH; i++)
            begin
                bank_ff[i] <= reset_value(regmap_pkg::reg_index_t'(i));
            end
        end
        else if (ce)
        begin
            for (int i = 0; i < regmap_pkg::BANK_DEPTH; i++)
            begin
                logic [7:0] sw;
                logic [7:0] nxt_byte;
                sw       = sw_bits(regmap_pkg::reg_index_t'(i));
                nxt_byte = bank_ff[i];
                // Peripheral side writes status and captured values
                if (hw_wr && (hw_index == 5'(i)))
                begin
                    nxt_byte = (nxt_byte & sw) | (hw_data & ~sw);
                end
                // Software side writes its own control bits
                if (bank_wr && (acc.index[4:0] == 5'(i)))
                begin
                    nxt_byte = (nxt_byte & ~sw) | (acc.wdata & sw);
                end
                // Fixed zeros never hold a one
                bank_ff[i] <= nxt_byte & live_bits(regmap_pkg::reg_index_t'(i));
            end
        end
    end

    // Power-on flag: set by a power-on reset, held by other resets,
    // cleared only by software writing zero to it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            if (power_on)
            begin
                power_on_ff <= 1'b1;
            end
        end
        else if (ce)
        begin
            if (bank_wr && (acc.index == regmap_pkg::IDX_MISC_CONTROL) &&
                !acc.wdata[regmap_pkg::MISC_POWER_ON_BIT])
            begin
                power_on_ff <= 1'b0;
            end
        end
    end

    // Watchdog enable: strap decides after every reset; software may
    // turn it on but, as a guard against runaway code, never off
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            watchdog_ff <= watchdog_mask_option;
        end
        else if (ce)
        begin
            if (bank_wr && (acc.index == regmap_pkg::IDX_MISC_CONTROL) &&
                acc.wdata[regmap_pkg::MISC_WATCHDOG_BIT])
            begin
                watchdog_ff <= 1'b1;
            end
        end
    end

    // Miscellaneous register as seen by software and peripherals
    always_comb
    begin
        misc_val = bank_ff[regmap_pkg::IDX_MISC_CONTROL[4:0]];
        misc_val[regmap_pkg::MISC_POWER_ON_BIT] = power_on_ff;
        misc_val[regmap_pkg::MISC_WATCHDOG_BIT] = watchdog_ff;
    end

    // Read decode; unmapped indices read zero but are still answered
    always_comb
    begin
        acc.rdata  = 8'h00;
        acc.mapped = 1'b0;
        if (acc.index == regmap_pkg::IDX_MISC_CONTROL)
        begin
            acc.rdata  = misc_val;
            acc.mapped = 1'b1;
        end
        else if (acc.index < regmap_pkg::reg_index_t'(regmap_pkg::BANK_DEPTH))
        begin
            acc.rdata  = bank_ff[acc.index[4:0]];
            acc.mapped = 1'b1;
        end
        else if (acc.index == regmap_pkg::IDX_PERSISTENT_OPTIONS)
        begin
            acc.rdata  = options_val;
            acc.mapped = 1'b1;
        end
        else
        begin
            acc.rdata  = 8'h00;
            acc.mapped = 1'b0;
        end
    end

    // Register image out to the peripherals
    always_comb
    begin
        for (int i = 0; i < regmap_pkg::BANK_DEPTH; i++)
        begin
            regs_o[i] = bank_ff[i];
        end
        regs_o[regmap_pkg::IDX_MISC_CONTROL[4:0]] = misc_val;
    end

    // Single-bit views and the options byte that other blocks need directly
    assign watchdog_enable_bit = watchdog_ff;
    assign power_on_seen       = power_on_ff;
    assign persistent_options  = options_val;
    assign security_bit        = options_val[0];

endmodule : peripheral_register_map_reset

/* reg_access_if.sv */
`timescale 1ns/1ps
// Decoded register access between the bus port and the register core
interface reg_access_if;
    logic                     wr_stb;  // One-cycle write commit
    regmap_pkg::reg_index_t   index;   // Register index
    logic [7:0]               wdata;   // Write byte
    logic [7:0]               rdata;   // Read byte from the core
    logic                     mapped;  // Index names a register

    modport bus
    (
        output wr_stb,
        output index,
        output wdata,
        input  rdata,
        input  mapped
    );

    modport core
    (
        input  wr_stb,
        input  index,
        input  wdata,
        output rdata,
        output mapped
    );
endinterface : reg_access_if

/* regmap_monitor.sv */
`timescale 1ns/1ps
// Watches the register map from its top ports only
module regmap_monitor
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             ce,
    // Reset cause and stored values
    input wire logic             power_on,
    input wire logic             watchdog_mask_option,
    input wire logic [7:0]       nv_image,
    // Bus
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    // Register image
    input wire logic [31:0][7:0] regs_o,
    input wire logic             watchdog_enable_bit,
    input wire logic             power_on_seen,
    input wire logic [7:0]       persistent_options
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // First edge after a reset that really ran
    sequence s_reset_end;
        $fell(rst) && $past(ce);
    endsequence
    // Request taken, then a one-cycle answer
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_dir_reset;
        s_reset_end |-> regs_o[4] == 8'h00 && regs_o[5] == 8'h00 && regs_o[6] == 8'h00;
    endproperty
    property p_pulse_reset;
        s_reset_end |-> regs_o[10] == 8'h00 && regs_o[11] == 8'h00;
    endproperty
    property p_serial_two_reset;
        s_reset_end |-> regs_o[15] == 8'h00;
    endproperty
    property p_power_on;
        s_reset_end ##0 $past(power_on) |-> power_on_seen && regs_o[12][7];
    endproperty
    property p_watchdog;
        s_reset_end |-> watchdog_enable_bit == $past(watchdog_mask_option)
            && regs_o[12][0] == watchdog_enable_bit;
    endproperty
    property p_options_kept;
        s_reset_end |-> persistent_options == ($past(nv_image) & 8'h03);
    endproperty
    property p_counter_reset;
        s_reset_end |-> regs_o[24] == 8'hff && regs_o[25] == 8'hfc
            && regs_o[26] == 8'hff && regs_o[27] == 8'hfc;
    endproperty
    property p_fixed_zero;
        persistent_options[7:2] == 6'h00 && regs_o[7][7:4] == 4'h0 && !regs_o[9][4];
    endproperty
    property p_ack;
        s_take |=> s_answer;
    endproperty
    property p_read_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty

    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
    a_pulse_reset: assert property (p_pulse_reset) else $error("pulse length set");
    a_serial_two_reset: assert property (p_serial_two_reset) else $error("ctl two set");
    a_power_on: assert property (p_power_on) else $error("power-on flag clear");
    a_watchdog: assert property (p_watchdog) else $error("watchdog enable wrong");
    a_options_kept: assert property (p_options_kept) else $error("options lost");
    a_counter_reset: assert property (p_counter_reset) else $error("counter reset");
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed zero bit set");
    a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
    a_read_upper: assert property (p_read_upper) else $error("read upper bits set");
endmodule : regmap_monitor

bind peripheral_register_map_reset regmap_monitor regmap_monitor_inst
(
    .clk(clk), .rst(rst), .ce(ce), .power_on(power_on),
    .watchdog_mask_option(watchdog_mask_option), .nv_image(nv_image),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .regs_o(regs_o), .watchdog_enable_bit(watchdog_enable_bit),
    .power_on_seen(power_on_seen), .persistent_options(persistent_options)
);

/* regmap_pkg.sv */
package regmap_pkg;

    // Register index; byte address on the bus is four times the index
    typedef logic [9:0] reg_index_t;

    // Register indices as printed
    localparam reg_index_t IDX_PORT_A_VALUE       = 10'h000;
    localparam reg_index_t IDX_PORT_B_VALUE       = 10'h001;
    localparam reg_index_t IDX_PORT_C_VALUE       = 10'h002;
    localparam reg_index_t IDX_PORT_D_VALUE       = 10'h003;
    localparam reg_index_t IDX_PORT_A_DIRECTION   = 10'h004;
    localparam reg_index_t IDX_PORT_B_DIRECTION   = 10'h005;
    localparam reg_index_t IDX_PORT_C_DIRECTION   = 10'h006;
    localparam reg_index_t IDX_NV_CLOCK_CONTROL   = 10'h007;
    localparam reg_index_t IDX_CONVERTER_RESULT   = 10'h008;
    localparam reg_index_t IDX_CONVERTER_STATUS   = 10'h009;
    localparam reg_index_t IDX_PULSE_LENGTH_A     = 10'h00a;
    localparam reg_index_t IDX_PULSE_LENGTH_B     = 10'h00b;
    localparam reg_index_t IDX_MISC_CONTROL       = 10'h00c;
    localparam reg_index_t IDX_SERIAL_RATE        = 10'h00d;
    localparam reg_index_t IDX_SERIAL_CONTROL_ONE = 10'h00e;
    localparam reg_index_t IDX_SERIAL_CONTROL_TWO = 10'h00f;
    localparam reg_index_t IDX_SERIAL_FLAGS       = 10'h010;
    localparam reg_index_t IDX_SERIAL_BUFFER      = 10'h011;
    localparam reg_index_t IDX_TIMER_CONTROL      = 10'h012;
    localparam reg_index_t IDX_TIMER_FLAGS        = 10'h013;
    localparam reg_index_t IDX_CAPTURE1_HIGH      = 10'h014;
    localparam reg_index_t IDX_CAPTURE1_LOW       = 10'h015;
    localparam reg_index_t IDX_COMPARE1_HIGH      = 10'h016;
    localparam reg_index_t IDX_COMPARE1_LOW       = 10'h017;
    localparam reg_index_t IDX_FREE_COUNTER_HIGH  = 10'h018;
    localparam reg_index_t IDX_FREE_COUNTER_LOW   = 10'h019;
    localparam reg_index_t IDX_ALT_COUNTER_HIGH   = 10'h01a;
    localparam reg_index_t IDX_ALT_COUNTER_LOW    = 10'h01b;
    localparam reg_index_t IDX_CAPTURE2_HIGH      = 10'h01c;
    localparam reg_index_t IDX_CAPTURE2_LOW       = 10'h01d;
    localparam reg_index_t IDX_COMPARE2_HIGH      = 10'h01e;
    localparam reg_index_t IDX_COMPARE2_LOW       = 10'h01f;
    localparam reg_index_t IDX_PERSISTENT_OPTIONS = 10'h100;

    // Size of the low register bank
    localparam int unsigned BANK_DEPTH = 32;

    // Values after reset
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [7:0] RST_COUNTER_HIGH  = 8'hff;
    localparam logic [7:0] RST_COUNTER_LOW   = 8'hfc;
    localparam logic [7:0] RST_SERIAL_FLAGS  = 8'hc0;
    localparam logic [7:0] RST_MISC_BASE     = 8'h10;

    // Fields of the miscellaneous register
    localparam int unsigned MISC_POWER_ON_BIT = 7;
    localparam int unsigned MISC_WATCHDOG_BIT = 0;

    // Bits that exist, all others reading zero; CONV_STATUS_SW_BITS marks those software may write
    localparam logic [7:0] NV_CLOCK_LIVE_BITS  = 8'h0f;
    localparam logic [7:0] CONV_STATUS_LIVE    = 8'hef;
    localparam logic [7:0] CONV_STATUS_SW_BITS = 8'h6f;
    localparam logic [7:0] OPTIONS_LIVE_BITS   = 8'h03;
    localparam logic [7:0] ALL_BITS            = 8'hff;
    localparam logic [7:0] NO_BITS             = 8'h00;

endpackage : regmap_pkg

/* tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the register map
module tb_top;
    // Design inputs
    logic             clk, rst, ce, power_on, watchdog_mask_option;
    logic             wb_cyc_i, wb_stb_i, wb_we_i, hw_wr;
    logic [11:0]      wb_adr_i;
    logic [3:0]       wb_sel_i;
    logic [31:0]      wb_dat_i;
    logic [4:0]       hw_index;
    logic [7:0]       hw_data, nv_image;
    // Design outputs
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o, watchdog_enable_bit, power_on_seen, security_bit, nv_commit;
    logic [31:0][7:0] regs_o;
    logic [7:0]       persistent_options;
    // Bench state
    int               error_cnt = 0;
    int               cmp_count = 0;
    int               commit_cnt = 0;
    logic [15:0]      lfsr = 16'hdeaf;
    logic [7:0]       mdl [0:31];  // Expected register contents
    logic [7:0]       d, nv0;
    logic             opt;
    int rst_idx[10] = '{4, 5, 6, 10, 11, 15, 24, 25, 26, 27};
    int rst_val[10] = '{0, 0, 0, 0, 0, 0, 255, 252, 255, 252};
    int wr_idx[11]  = '{4, 5, 6, 10, 11, 14, 15, 22, 23, 30, 31};
    int cap_idx[4]  = '{20, 21, 28, 29};

    peripheral_register_map_reset peripheral_register_map_reset_inst
    (
        .clk, .rst, .ce, .power_on, .watchdog_mask_option, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_wr,
        .hw_index, .hw_data, .regs_o, .watchdog_enable_bit, .power_on_seen,
        .nv_image, .persistent_options, .security_bit, .nv_commit
    );

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Stored cells take the mirrored value on each commit pulse
    always @(posedge clk)
        if (nv_commit === 1'b1)
        begin
            nv_image <= persistent_options;
            commit_cnt++;
        end

    // Shift register source of random bytes
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    // Byte comparison, the only kind of result here
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Classic single cycle; holds the request until ack is sampled
    task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] wd,
                           output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        check("bus ack", 8'h01, {7'h00, wb_ack_o});
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input int idx, input logic [7:0] wd);
        logic [7:0] v;
        wb_xfer(1'b1, 10'(idx), wd, v);
    endtask : wr

    task automatic rd_chk(input int idx, input logic [7:0] exp);
        logic [7:0] v;
        wb_xfer(1'b0, 10'(idx), 8'h00, v);
        check($sformatf("reg %0h", idx), exp, v);
    endtask : rd_chk

    // Reset with a chosen cause and watchdog strap
    task automatic do_reset(input logic pon, input logic wdo);
        @(posedge clk);
        rst <= 1'b1;
        power_on <= pon;
        watchdog_mask_option <= wdo;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        power_on <= 1'b0;
    endtask : do_reset

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // Cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial
    begin
        {rst, ce, wb_sel_i} = {1'b1, 1'b1, 4'h1};
        {power_on, wb_cyc_i, wb_stb_i, wb_we_i, hw_wr} = '0;
        {wb_adr_i, wb_dat_i, hw_index, hw_data} = '0;
        nv0 = rnd();
        nv_image = nv0;
        opt = nv0[0];
        watchdog_mask_option = opt;
        // Power-on reset, then the documented reset image
        do_reset(1'b1, opt);
        check("watchdog bit", {7'h00, opt}, {7'h00, watchdog_enable_bit});
        check("power-on flag", 8'h01, {7'h00, power_on_seen});
        check("security bit", {7'h00, nv0[0]}, {7'h00, security_bit});
        foreach (rst_idx[i]) rd_chk(rst_idx[i], 8'(rst_val[i]));
        rd_chk(12, 8'h90 | {7'h00, opt});
        rd_chk(256, nv0 & 8'h03);
        // Writes to the plain registers, one idle cycle apart, then read back
        foreach (wr_idx[i])
        begin
            d = rnd();
            mdl[wr_idx[i]] = d;
            wr(wr_idx[i], d);
        end
        foreach (wr_idx[i]) rd_chk(wr_idx[i], mdl[wr_idx[i]]);
        // Capture bytes come from the peripheral side only
        foreach (cap_idx[i])
        begin
            d = rnd();
            mdl[cap_idx[i]] = d;
            @(posedge clk);
            hw_wr <= 1'b1;
            hw_index <= 5'(cap_idx[i]);
            hw_data <= d;
            @(posedge clk);
            hw_wr <= 1'b0;
            wr(cap_idx[i], ~d);
        end
        foreach (cap_idx[i]) rd_chk(cap_idx[i], mdl[cap_idx[i]]);
        // Clock enable low must freeze the bank against a peripheral write
        @(posedge clk);
        ce <= 1'b0;
        hw_wr <= 1'b1;
        hw_index <= 5'd20;
        hw_data <= ~mdl[20];
        @(posedge clk);
        ce <= 1'b1;
        hw_wr <= 1'b0;
        rd_chk(20, mdl[20]);
        // Fixed zero bits and the unmapped hole
        wr(7, 8'hff);
        rd_chk(7, 8'h0f);
        wr(9, 8'hff);
        rd_chk(9, 8'h6f);
        wr(256, 8'hff);
        rd_chk(256, 8'h03);
        check("commit pulses", 8'h01, 8'(commit_cnt));
        wr(64, 8'hff);
        rd_chk(64, 8'h00);
        // Clear the power-on flag; a later plain reset must keep it clear
        wr(12, 8'h00);
        rd_chk(12, 8'h10 | {7'h00, opt});
        do_reset(1'b0, ~opt);
        check("power-on kept", 8'h00, {7'h00, power_on_seen});
        rd_chk(12, 8'h10 | {7'h00, ~opt});
        rd_chk(256, 8'h03);
        foreach (rst_idx[i]) rd_chk(rst_idx[i], 8'(rst_val[i]));
        final_report();
    end
endmodule : tb_top

/* wb_classic_port.sv */
`timescale 1ns/1ps
module wb_classic_port
#(
    parameter int ADDR_W = 12
)
(
    // Clock and control
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Decoded access
    reg_access_if.bus              acc
);

    logic        ack_ff;   // Answer, one cycle wide
    logic [31:0] dat_ff;   // Read word held for the master
    logic        req;      // Live request

    assign req      = wb_cyc_i & wb_stb_i;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // Word addressing: the two low byte-address bits are ignored
    assign acc.index  = regmap_pkg::reg_index_t'(wb_adr_i[ADDR_W-1:2]);
    assign acc.wdata  = wb_dat_i[7:0];
    // Writes commit on the edge where the master sees ack, lane 0 only
    assign acc.wr_stb = req & wb_we_i & wb_sel_i[0] & ack_ff & ce;

    // Ack one cycle after the request; it drops on its own next cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_ff <= req & ~ack_ff;
            // Read data sampled with the ack so it comes from flops
            if (req & ~ack_ff & ~wb_we_i)
            begin
                dat_ff <= {24'h00_0000, acc.rdata};
            end
        end
    end

endmodule : wb_classic_port
